// >>> rtl/rcd_drive.sv
// Reel and capstan drive control with a classic Wishbone register slave.
`timescale 1ns/10ps
module rcd_drive #(
	parameter int unsigned STILL_CYC = rcd_pkg::STILL_CYC_DEF,
	parameter int unsigned PROP_CYC = rcd_pkg::PROP_CYC_DEF,
	parameter int unsigned TACH75_CYC = rcd_pkg::TACH75_CYC_DEF,
	parameter int unsigned TACH120_CYC = rcd_pkg::TACH120_CYC_DEF,
	parameter int unsigned TACH125_CYC = rcd_pkg::TACH125_CYC_DEF,
	parameter int unsigned TACH200_CYC = rcd_pkg::TACH200_CYC_DEF,
	parameter int G16_DIV = rcd_pkg::G16_DIV
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Motion tags from the controller.
	input wire logic move_tag_i,
	input wire logic fwd_i,
	input wire logic rev_i,
	// Column switches, bit k high while the loop is below port k+1.
	input wire logic [3:0] left_col_i,
	input wire logic [3:0] right_col_i,
	// Tachs and tape sensors.
	input wire logic left_tach_i,
	input wire logic right_tach_i,
	input wire logic cap_tach_i,
	input wire logic radius_i,
	input wire logic eot_i,
	input wire logic bot_i,
	// Reel commands, bit 0 left and bit 1 right.
	output logic manual_status_o,
	output logic reel_full_o,
	output rcd_pkg::rcd_speed_type speed_class_o,
	output logic hs_status_o,
	output logic [1:0] reel_drive_o,
	output logic [1:0] reel_gnd_a_o,
	output logic [1:0] reel_gnd_b_o,
	output logic [1:0] reel_ccw_o,
	output logic [1:0] anti_bobble_o,
	// Capstan commands and status.
	output logic cap_drive_o,
	output logic cap_coast_o,
	output logic cap_fwd_o,
	output logic cap_cmp_sel_o,
	output logic go_back_o,
	output logic eot_o
);
	import rcd_pkg::*;

	localparam int GW = $clog2(G16_DIV);
	localparam logic [GW-1:0] G16_LAST = GW'(G16_DIV - 1);

	logic [16:0] meta_reg, sync_reg;
	logic [11:0] prev_reg;
	logic [3:0] ctrl_reg, creep_reg, creep_next;
	logic [31:0] rdat_reg, still_reg, still_next, per_reg, per_next;
	rcd_state_type state_reg, state_next;
	logic [GW-1:0] g16_reg, g16_next;
	logic [1:0] seen_reg, seen_next, fast_reg, fast_next, ccw_reg, bobble_reg;
	logic ack_reg, unload_reg, unload_next, ord_drive_reg, ord_drive_next;
	logic rf_latch_reg, rf_latch_next, cap_drive_reg, cap_drive_next, cap_fwd_reg, cap_fwd_next;
	logic stepped_reg, stepped_next, manual_reg, hs_reg, go_back_reg, pd_act, pc_act;
	rcd_reel_type rs_l_reg, rs_l_next, rs_r_reg, rs_r_next;
	rcd_speed_type speed_reg, speed_next;

	// Pin synchroniser; logic reads the second stage and its delayed copy in prev_reg, never the first.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_reg <= 17'h0;
			sync_reg <= 17'h0;
			prev_reg <= 12'h0;
		end else begin
			meta_reg <= {move_tag_i, fwd_i, rev_i, bot_i, eot_i, radius_i,
				cap_tach_i, right_tach_i, left_tach_i, right_col_i, left_col_i};
			sync_reg <= meta_reg;
			prev_reg <= sync_reg[11:0];
		end
	end

	// Registered column levels and squared tach edges.
	wire [3:0] lc = sync_reg[3:0];
	wire [3:0] rc = sync_reg[7:4];
	wire [2:0] tach_pulse = sync_reg[10:8] & ~prev_reg[10:8];
	wire [1:0] reel_pulse = tach_pulse[1:0];
	wire cap_pulse = tach_pulse[2];
	wire radius_pulse = sync_reg[11] & ~prev_reg[11];
	wire eot_s = sync_reg[12];
	wire bot_s = sync_reg[13];
	wire rv = sync_reg[14];
	wire fw = sync_reg[15];
	wire mv = sync_reg[16];
	wire [3:0] lc_rise = lc & ~prev_reg[3:0];
	wire [3:0] lc_fall = ~lc & prev_reg[3:0];
	wire [3:0] rc_rise = rc & ~prev_reg[7:4];
	wire [3:0] rc_fall = ~rc & prev_reg[7:4];

	// Bus-out decode of the motion tags; both lines at once means no motion.
	wire go_fwd = mv & fw & ~rv;
	wire go_back = mv & rv & ~fw;

	// Wishbone decode; writes commit on the edge where ack is high.
	wire wb_req = wb_cyc_i & wb_stb_i;
	wire wb_commit = wb_req & ack_reg & wb_we_i & wb_sel_i[0];
	wire hit_ctrl = (wb_adr_i == ADDR_CTRL);
	wire hit_cmd = (wb_adr_i == ADDR_CMD);
	wire hit_stat = (wb_adr_i == ADDR_STAT);
	wire [3:0] cmd = (wb_commit & hit_cmd) ? wb_dat_i[3:0] : 4'h0;
	wire cmd_load = cmd[CMD_LOAD];
	wire cmd_rewind = cmd[CMD_REWIND];
	wire cmd_unload = cmd[CMD_UNLOAD];
	wire cmd_stepdown = cmd[CMD_STEPDOWN];
	wire [1:0] model = ctrl_reg[CTRL_MODEL_LSB +: 2];
	wire hs_en = ctrl_reg[CTRL_HS_EN];
	wire thread = ctrl_reg[CTRL_THREAD];
	wire [31:0] stat_word = {17'h0, rs_r_reg, rs_l_reg, unload_reg, bot_s, eot_s,
		rf_latch_reg, fast_reg, speed_reg, state_reg};
	wire [31:0] rd_mux = hit_ctrl ? {28'h0, ctrl_reg} : (hit_stat ? stat_word : 32'h0);

	// Bus slave: ack one cycle after the request, read data captured with it.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_reg <= 1'b0;
			rdat_reg <= 32'h0;
			ctrl_reg <= CTRL_RESET;
		end else begin
			ack_reg <= wb_req & ~ack_reg;
			if (wb_req & ~ack_reg) begin
				rdat_reg <= rd_mux;
			end
			if (wb_commit & hit_ctrl) begin
				ctrl_reg <= wb_dat_i[3:0];
			end
		end
	end
	assign wb_ack_o = ack_reg;
	assign wb_dat_o = rdat_reg;

	// Unit sequence.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			ST_MANUAL: begin
				if (cmd_load) begin
					state_next = ST_STOP;
				end
			end
			ST_STOP: begin
				if (cmd_unload & bot_s) begin
					state_next = ST_MANUAL;
				end else if ((cmd_rewind | cmd_unload) & ~bot_s) begin
					state_next = (still_reg >= STILL_CYC) ? ST_CREEP : ST_REW;
				end else if (go_fwd | go_back) begin
					state_next = ST_MOVE;
				end
			end
			ST_MOVE: begin
				if (~(go_fwd | go_back)) begin
					state_next = ST_STOP;
				end
			end
			ST_CREEP: begin
				if (creep_reg == CREEP_COUNTS) begin
					state_next = ST_REW;
				end
			end
			ST_REW: begin
				if (bot_s) begin
					state_next = unload_reg ? ST_MANUAL : ST_STOP;
				end else if (hs_en & (&fast_reg) & ~cmd_stepdown & ~stepped_reg) begin
					state_next = ST_FAST;
				end
			end
			ST_FAST: begin
				if (bot_s) begin
					state_next = unload_reg ? ST_MANUAL : ST_STOP;
				end else if (radius_pulse | cmd_stepdown) begin
					state_next = ST_REW;
				end
			end
			default: begin
				state_next = ST_MANUAL;
			end
		endcase
	end

	// Counters: still time, creep length, divide by 16, capstan period.
	wire moving = (state_reg != ST_MANUAL) & (state_reg != ST_STOP);
	wire [31:0] target = (model == MODEL_3) ? ((state_reg == ST_REW) ? TACH120_CYC : TACH75_CYC)
		: ((model == MODEL_5) ? TACH125_CYC : TACH200_CYC);
	wire per_slow = (per_reg >= target);
	wire hold = (state_reg == ST_FAST);
	wire g16_pulse = cap_pulse & (g16_reg == G16_LAST);
	assign unload_next = (unload_reg | (cmd_unload & (state_reg != ST_MANUAL)))
		& (state_next != ST_MANUAL);
	// After a step down the rewind stays at normal speed, even while the ahead flags linger.
	assign stepped_next = (state_next == ST_REW) & (stepped_reg | (state_reg == ST_FAST));
	assign still_next = moving ? 32'h0 : ((still_reg >= STILL_CYC) ? still_reg : still_reg + 32'h1);
	assign creep_next = (state_reg == ST_CREEP) ? creep_reg + {3'h0, cap_pulse} : 4'h0;
	assign g16_next = cap_pulse ? ((g16_reg == G16_LAST) ? '0 : g16_reg + GW'(1)) : g16_reg;
	assign per_next = (hold | cap_pulse) ? 32'h0 : (per_slow ? per_reg : per_reg + 32'h1);
	// Holding the fast trigger in drive keeps ordinary control from coasting.
	assign ord_drive_next = hold | (~cap_pulse & (per_slow | ord_drive_reg));

	// Reel ahead of capstan: two reel pulses inside one divider window.
	assign seen_next = g16_pulse ? reel_pulse : (seen_reg | reel_pulse);
	assign fast_next = (fast_reg & ~({2{g16_pulse}} & ~seen_reg & ~reel_pulse))
		| (reel_pulse & seen_reg);

	// Column arbitration; checking coast first makes it win.
	wire col_coast = ~lc[0] | rc[3];
	wire col_drive = lc[2] | ~rc[1];
	assign rf_latch_next = col_coast | (~col_drive & rf_latch_reg);

	// Proportional corrections are only armed while rewinding.
	wire rew_act = (state_reg == ST_REW) | hold;
	wire pd_trig = rew_act & (lc_rise[0] | rc_fall[2]);
	wire pc_trig = rew_act & (lc_fall[1] | rc_rise[3]);
	rcd_oneshot #(.LEN_CYC(PROP_CYC)) u_pd (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.trig_i(pd_trig),
		.pulse_o(pd_act)
	);
	rcd_oneshot #(.LEN_CYC(PROP_CYC)) u_pc (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.trig_i(pc_trig),
		.pulse_o(pc_act)
	);

	// Capstan command: high power drive or coast, never both.
	always_comb begin
		cap_drive_next = 1'b0;
		cap_fwd_next = 1'b1;
		case (state_reg)
			ST_MOVE: begin
				cap_drive_next = ord_drive_reg;
				cap_fwd_next = go_fwd;
			end
			ST_CREEP: begin
				cap_drive_next = ord_drive_reg;
			end
			ST_REW: begin
				cap_drive_next = (ord_drive_reg | pd_act) & ~pc_act;
				cap_fwd_next = 1'b0;
			end
			ST_FAST: begin
				cap_drive_next = (((&fast_reg) & ~rf_latch_reg) | pd_act) & ~pc_act;
				cap_fwd_next = 1'b0;
			end
			default: begin
				cap_drive_next = 1'b0;
			end
		endcase
	end

	// Reel requests from the columns; in high speed a reel ahead of the capstan coasts.
	wire [1:0] reel_req = {rc[1] | ~rc[0], ~lc[1] | lc[2]};
	wire [1:0] reel_hold = hold ? fast_reg : 2'h0;
	wire brake_all = (state_reg == ST_MANUAL) & ~thread;
	assign rs_l_next = brake_all ? REEL_BRAKE
		: ((reel_req[0] & ~reel_hold[0]) ? REEL_DRIVE : REEL_COAST);
	assign rs_r_next = brake_all ? REEL_BRAKE
		: ((reel_req[1] & ~reel_hold[1]) ? REEL_DRIVE : REEL_COAST);
	assign speed_next = (state_next == ST_MANUAL) ? SPD_LOW
		: ((state_next == ST_FAST) ? SPD_HIGH : SPD_NORM);

	// State and output registers.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= ST_MANUAL;
			unload_reg <= 1'b0;
			stepped_reg <= 1'b0;
			still_reg <= 32'h0;
			creep_reg <= 4'h0;
			g16_reg <= '0;
			seen_reg <= 2'h0;
			fast_reg <= 2'h0;
			per_reg <= 32'h0;
			ord_drive_reg <= 1'b0;
			rf_latch_reg <= 1'b1;
			cap_drive_reg <= 1'b0;
			cap_fwd_reg <= 1'b1;
			rs_l_reg <= REEL_BRAKE;
			rs_r_reg <= REEL_BRAKE;
			ccw_reg <= 2'h0;
			manual_reg <= 1'b1;
			hs_reg <= 1'b0;
			speed_reg <= SPD_LOW;
			bobble_reg <= 2'h0;
			go_back_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			unload_reg <= unload_next;
			stepped_reg <= stepped_next;
			still_reg <= still_next;
			creep_reg <= creep_next;
			g16_reg <= g16_next;
			seen_reg <= seen_next;
			fast_reg <= fast_next;
			per_reg <= per_next;
			ord_drive_reg <= ord_drive_next;
			rf_latch_reg <= rf_latch_next;
			cap_drive_reg <= cap_drive_next;
			cap_fwd_reg <= cap_fwd_next;
			rs_l_reg <= rs_l_next;
			rs_r_reg <= rs_r_next;
			ccw_reg <= {rc[1], ~lc[1]};
			manual_reg <= (state_next == ST_MANUAL);
			hs_reg <= (state_next == ST_FAST);
			speed_reg <= speed_next;
			bobble_reg <= {2{state_next == ST_STOP}};
			go_back_reg <= go_back;
		end
	end

	// Output mapping; brake is both armature sides grounded.
	assign manual_status_o = manual_reg;
	assign reel_full_o = ~manual_reg;
	assign speed_class_o = speed_reg;
	assign hs_status_o = hs_reg;
	assign reel_drive_o = {rs_r_reg == REEL_DRIVE, rs_l_reg == REEL_DRIVE};
	assign reel_gnd_a_o = {rs_r_reg == REEL_BRAKE, rs_l_reg == REEL_BRAKE};
	assign reel_gnd_b_o = {rs_r_reg == REEL_BRAKE, rs_l_reg == REEL_BRAKE};
	assign reel_ccw_o = ccw_reg;
	assign anti_bobble_o = bobble_reg;
	assign cap_drive_o = cap_drive_reg;
	assign cap_coast_o = ~cap_drive_reg;
	assign cap_fwd_o = cap_fwd_reg;
	assign cap_cmp_sel_o = hs_reg;
	assign go_back_o = go_back_reg;
	assign eot_o = eot_s;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	load_clear_a: assert property ((state_reg == ST_MANUAL) && cmd_load |=>
		!manual_status_o && reel_full_o) else $error("load did not leave manual");
	manual_line_a: assert property (manual_status_o |->
		speed_class_o == SPD_LOW && !hs_status_o) else $error("manual line mismatch");
	brake_gnd_a: assert property (reel_gnd_a_o == reel_gnd_b_o &&
		(reel_drive_o & reel_gnd_a_o) == 2'h0) else $error("brake not both sides");
	g16_wrap_a: assert property (cap_pulse && g16_reg == G16_LAST |=>
		g16_reg == '0 ##1 g16_reg == '0 || cap_pulse) else $error("divider wrap wrong");
	coast_wins_a: assert property (col_coast && col_drive |=>
		rf_latch_reg) else $error("drive beat coast");
	stop_coast_a: assert property ((state_reg == ST_MOVE) && !mv |=>
		state_reg == ST_STOP ##1 cap_coast_o) else $error("no coast after move drop");
	hs_reset_a: assert property (hold && radius_pulse && !bot_s |=>
		state_reg == ST_REW && speed_class_o == SPD_NORM) else $error("radius missed");
	fast_entry_a: assert property ((state_reg == ST_REW) && hs_en && fast_reg == 2'h3
		&& !bot_s && !cmd_stepdown && !stepped_reg |=> hs_status_o && cap_cmp_sel_o)
		else $error("no fast");
	creep_len_a: assert property ((state_reg == ST_CREEP) ##1 (state_reg == ST_REW) |->
		$past(creep_reg) == CREEP_COUNTS) else $error("creep length wrong");
	bobble_a: assert property ((state_reg == ST_STOP) |->
		anti_bobble_o == 2'h3) else $error("anti-bobble missing");
	go_back_a: assert property (mv && rv && !fw |=> go_back_o) else $error("no go back");
	bus_ack_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");

	fast_seen_c: cover property (state_reg == ST_FAST ##1 state_reg == ST_REW);
	creep_seen_c: cover property (state_reg == ST_CREEP ##1 state_reg == ST_REW);
	back_seen_c: cover property ((state_reg == ST_MOVE) && go_back);
	prop_seen_c: cover property (pd_act && pc_act);
endmodule // rcd_drive

// >>> common/rcd_pkg.sv
// Constants and types shared by the reel and capstan drive control.
package rcd_pkg;
	// Wishbone byte offsets of the three registers.
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_CMD = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;

	// Control register fields and value after reset.
	localparam int CTRL_MODEL_LSB = 0;
	localparam int CTRL_HS_EN = 2;
	localparam int CTRL_THREAD = 3;
	localparam logic [3:0] CTRL_RESET = 4'h4;

	// Command register bits; each is a one-shot write.
	localparam int CMD_LOAD = 0;
	localparam int CMD_REWIND = 1;
	localparam int CMD_UNLOAD = 2;
	localparam int CMD_STEPDOWN = 3;

	// Model select values; any other value means the fastest model.
	localparam logic [1:0] MODEL_3 = 2'h0;
	localparam logic [1:0] MODEL_5 = 2'h1;

	// Clock and time figures.
	localparam int CLK_NS = 10;
	localparam int NS_PER_MS = 1000000;
	localparam int STILL_MS = 12;
	localparam int PROP_MS = 2;
	localparam int TENTHS = 10;

	// Capstan tach rates in tenths of a pulse per millisecond.
	localparam int RATE_75 = 80;
	localparam int RATE_120 = 128;
	localparam int RATE_125 = 133;
	localparam int RATE_200 = 213;

	// Cycle counts derived from the figures above; least times round up.
	localparam int unsigned STILL_CYC_DEF = (STILL_MS * NS_PER_MS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned PROP_CYC_DEF = (PROP_MS * NS_PER_MS + CLK_NS - 1) / CLK_NS;
	localparam int unsigned TACH75_CYC_DEF = (NS_PER_MS * TENTHS) / (RATE_75 * CLK_NS);
	localparam int unsigned TACH120_CYC_DEF = (NS_PER_MS * TENTHS) / (RATE_120 * CLK_NS);
	localparam int unsigned TACH125_CYC_DEF = (NS_PER_MS * TENTHS) / (RATE_125 * CLK_NS);
	localparam int unsigned TACH200_CYC_DEF = (NS_PER_MS * TENTHS) / (RATE_200 * CLK_NS);

	// Rewind creep length and capstan divider.
	localparam logic [3:0] CREEP_COUNTS = 4'h8;
	localparam int G16_DIV = 16;

	// Unit states; Gray steps along stop, creep, rewind, high speed.
	typedef enum logic [2:0] {
		ST_MANUAL = 3'h0,
		ST_STOP = 3'h1,
		ST_CREEP = 3'h3,
		ST_REW = 3'h2,
		ST_FAST = 3'h6,
		ST_MOVE = 3'h5
	} rcd_state_type;

	// Reel speed classes.
	typedef enum logic [1:0] {
		SPD_LOW = 2'h0,
		SPD_NORM = 2'h1,
		SPD_HIGH = 2'h2
	} rcd_speed_type;

	// Reel motor states.
	typedef enum logic [1:0] {
		REEL_COAST = 2'h0,
		REEL_DRIVE = 2'h1,
		REEL_BRAKE = 2'h2
	} rcd_reel_type;
endpackage

// >>> rtl/rcd_oneshot.sv
// Retriggerable one-shot that stretches a trigger into a timed pulse.
`timescale 1ns/10ps
module rcd_oneshot #(
	parameter int unsigned LEN_CYC = 200000
) (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Trigger and stretched pulse.
	input wire logic trig_i,
	output logic pulse_o
);
	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;

	// A new trigger restarts the interval, so a dithering loop keeps it lit.
	assign cnt_next = trig_i ? LEN_CYC : ((cnt_reg != 32'h0) ? cnt_reg - 32'h1 : 32'h0);
	assign pulse_o = (cnt_reg != 32'h0);

	// Interval counter.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_reg <= 32'h0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	pulse_start_a: assert property (@(posedge clk_i) disable iff (rst_i)
		trig_i |=> pulse_o [*2]) else $error("one-shot did not stretch its trigger");
endmodule // rcd_oneshot

// >>> tb/rcd_tester.sv
// Motion tag model of the tape control that drives the unit.
`timescale 1ns/10ps
module rcd_tester (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wanted motion: 0 stop, 1 forward, 2 backward.
	input wire logic [1:0] run_i,
	// End of tape reported by the unit.
	input wire logic eot_i,
	// Motion tags.
	output logic move_tag_o,
	output logic fwd_o,
	output logic rev_o
);
	logic eot_seen_reg;
	logic stop_fwd;

	// Once the marker is seen, forward motion stays off until the bench asks again.
	assign stop_fwd = eot_i || eot_seen_reg;

	// Tags change just after the edge, as a real controller would drive them.
	always_ff @(posedge clk_i) begin
		eot_seen_reg <= !rst_i && run_i == 2'h1 && stop_fwd;
		move_tag_o <= !rst_i && (run_i == 2'h2 || (run_i == 2'h1 && !stop_fwd));
		fwd_o <= !rst_i && run_i == 2'h1;
		rev_o <= !rst_i && run_i == 2'h2;
	end
endmodule // rcd_tester

// >>> tb/rcd_drive_test.sv
// Self-checking bench for the reel and capstan drive control.
`timescale 1ns/10ps
module rcd_drive_test;
	import rcd_pkg::*;
	typedef struct {logic [1:0] run; logic back; logic cfwd;} rcd_row_type;
	rcd_row_type rows [2] = '{'{2'h1, 1'b0, 1'b1}, '{2'h2, 1'b1, 1'b0}};
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hf;
	logic [3:0] sel = 4'hf;
	logic [31:0] wb_dat_i = 32'h0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic move_tag_i, fwd_i, rev_i, eot_o;
	logic [1:0] run = 2'h0;
	logic [3:0] left_col_i = 4'h0;
	logic [3:0] right_col_i = 4'h0;
	logic left_tach_i = 1'b0, right_tach_i = 1'b0, cap_tach_i = 1'b0;
	logic radius_i = 1'b0, eot_i = 1'b0, bot_i = 1'b0;
	logic manual_status_o, reel_full_o, hs_status_o, cap_drive_o, cap_coast_o;
	logic cap_fwd_o, cap_cmp_sel_o, go_back_o;
	rcd_speed_type speed_class_o;
	logic [1:0] reel_drive_o, reel_gnd_a_o, reel_gnd_b_o, reel_ccw_o, anti_bobble_o;
	logic [31:0] rd;
	int n_fail = 0;
	int n_compared = 0;

	// Free running 100 MHz clock.
	always #5 clk_i = ~clk_i;

	// Short counts keep the run brief; expectations follow these values.
	rcd_drive #(.STILL_CYC(50), .PROP_CYC(5), .TACH75_CYC(30), .TACH120_CYC(25),
		.TACH125_CYC(24)) DUT (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.move_tag_i(move_tag_i), .fwd_i(fwd_i), .rev_i(rev_i), .left_col_i(left_col_i),
		.right_col_i(right_col_i), .left_tach_i(left_tach_i), .right_tach_i(right_tach_i),
		.cap_tach_i(cap_tach_i), .radius_i(radius_i), .eot_i(eot_i), .bot_i(bot_i),
		.manual_status_o(manual_status_o), .reel_full_o(reel_full_o),
		.speed_class_o(speed_class_o), .hs_status_o(hs_status_o), .reel_drive_o(reel_drive_o),
		.reel_gnd_a_o(reel_gnd_a_o), .reel_gnd_b_o(reel_gnd_b_o), .reel_ccw_o(reel_ccw_o),
		.anti_bobble_o(anti_bobble_o), .cap_drive_o(cap_drive_o), .cap_coast_o(cap_coast_o),
		.cap_fwd_o(cap_fwd_o), .cap_cmp_sel_o(cap_cmp_sel_o), .go_back_o(go_back_o),
		.eot_o(eot_o));

	// The controller model stands on the tag side.
	rcd_tester tester (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .eot_i(eot_o),
		.move_tag_o(move_tag_i), .fwd_o(fwd_i), .rev_o(rev_i));

	// Counts the comparison and reports a difference at once.
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", what, exp, got);
			n_fail++;
		end
	endtask

	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// One classic cycle; ack and read data are taken at the same rising edge, then released.
	task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
		int i;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_sel_i <= sel;
		wb_adr_i <= adr;
		wb_dat_i <= dat;
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (wb_ack_o !== 1'b1 && i < 50);
		if (i >= 50) begin
			$display("mismatch ack expected 1 seen none");
			n_fail++;
			test_done;
		end
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	// Tach pulse long enough to pass the input synchronisers; mask is cap, right, left.
	task automatic tick(input logic [2:0] m);
		@(posedge clk_i);
		{cap_tach_i, right_tach_i, left_tach_i} <= m;
		cyc(3);
		{cap_tach_i, right_tach_i, left_tach_i} <= 3'h0;
		cyc(3);
	endtask

	// Main sequence: reset, motion rows, then the awkward cases.
	initial begin
		cyc(20);
		rst_i <= 1'b0;
		cyc(2);
		@(negedge clk_i);
		check("manual", 1, manual_status_o);
		check("full", 0, reel_full_o);
		check("speed", SPD_LOW, speed_class_o);
		check("brake", 6'h3c, {reel_gnd_a_o, reel_gnd_b_o, reel_drive_o});
		check("coast", 1, cap_coast_o);
		wb(1'b0, ADDR_CTRL, 32'h0);
		check("ctrl", 32'h4, rd);
		wb(1'b1, 8'h20, 32'hffff);
		wb(1'b0, 8'h20, 32'h0);
		check("unmapped", 0, rd);
		wb(1'b1, ADDR_CMD, 32'h1 << CMD_LOAD);
		cyc(2);
		@(negedge clk_i);
		check("manual", 0, manual_status_o);
		check("full", 1, reel_full_o);
		check("speed", SPD_NORM, speed_class_o);
		check("bobble", 3, anti_bobble_o);
		$display("reset and load test done");
		foreach (rows[k]) begin
			@(posedge clk_i);
			run <= rows[k].run;
			cyc(7);
			@(negedge clk_i);
			check("go_back", rows[k].back, go_back_o);
			check("cap_fwd", rows[k].cfwd, cap_fwd_o);
			check("bobble", 0, anti_bobble_o);
			@(posedge clk_i);
			run <= 2'h0;
			cyc(7);
			@(negedge clk_i);
			check("coast", 1, cap_coast_o);
			check("bobble", 3, anti_bobble_o);
			$display("motion row %0d test done", k);
		end
		@(posedge clk_i);
		run <= 2'h1;
		cyc(7);
		eot_i <= 1'b1;
		cyc(10);
		wb(1'b0, ADDR_STAT, 32'h0);
		check("eot_state", 1, rd[2:0]);
		@(negedge clk_i);
		check("eot", 1, eot_o);
		@(posedge clk_i);
		run <= 2'h0;
		eot_i <= 1'b0;
		$display("end of tape test done");
		left_col_i <= 4'h7;
		right_col_i <= 4'h3;
		cyc(6);
		wb(1'b0, ADDR_STAT, 32'h0);
		check("latch_drive", 0, rd[7]);
		@(negedge clk_i);
		check("ccw", 2, reel_ccw_o);
		@(posedge clk_i);
		right_col_i <= 4'hf;
		cyc(6);
		wb(1'b0, ADDR_STAT, 32'h0);
		check("latch_coast", 1, rd[7]);
		// A write with the low lane disabled must leave the control register alone.
		sel = 4'he;
		wb(1'b1, ADDR_CTRL, 32'h0);
		sel = 4'hf;
		wb(1'b0, ADDR_CTRL, 32'h0);
		check("sel_off", 32'h4, rd);
		$display("column test done");
		cyc(60);
		wb(1'b1, ADDR_CMD, 32'h1 << CMD_REWIND);
		cyc(2);
		wb(1'b0, ADDR_STAT, 32'h0);
		check("creep", 3, rd[2:0]);
		@(negedge clk_i);
		check("creep_fwd", 1, cap_fwd_o);
		repeat (8) tick(3'h4);
		cyc(4);
		wb(1'b0, ADDR_STAT, 32'h0);
		check("rewind", 2, rd[2:0]);
		@(negedge clk_i);
		check("rew_dir", 0, cap_fwd_o);
		check("rew_sel", 0, cap_cmp_sel_o);
		// Ordinary control has settled on drive; a right loop rising past R4 coasts briefly.
		@(posedge clk_i);
		right_col_i <= 4'h3;
		cyc(20);
		right_col_i <= 4'hf;
		cyc(4);
		@(negedge clk_i);
		check("prop_coast", 1, cap_coast_o);
		cyc(8);
		@(negedge clk_i);
		check("prop_end", 1, cap_drive_o);
		repeat (3) tick(3'h3);
		cyc(4);
		wb(1'b0, ADDR_STAT, 32'h0);
		check("fast", 6, rd[2:0]);
		@(negedge clk_i);
		check("hs", 1, hs_status_o);
		check("fast_speed", SPD_HIGH, speed_class_o);
		check("fast_sel", 1, cap_cmp_sel_o);
		@(posedge clk_i);
		radius_i <= 1'b1;
		cyc(3);
		radius_i <= 1'b0;
		cyc(4);
		@(negedge clk_i);
		check("hs_end", 0, hs_status_o);
		check("slow_speed", SPD_NORM, speed_class_o);
		repeat (32) tick(3'h4);
		cyc(4);
		wb(1'b0, ADDR_STAT, 32'h0);
		check("ahead", 0, rd[6:5]);
		check("stays_slow", 2, rd[2:0]);
		bot_i <= 1'b1;
		cyc(6);
		wb(1'b0, ADDR_STAT, 32'h0);
		check("at_bot", 1, rd[2:0]);
		// Unload at the marker, then thread lets the reels follow the columns.
		wb(1'b1, ADDR_CMD, 32'h1 << CMD_UNLOAD);
		wb(1'b1, ADDR_CTRL, 32'hc);
		cyc(2);
		@(negedge clk_i);
		check("unloaded", 1, manual_status_o);
		check("thread", 4'h3, {reel_gnd_a_o, reel_drive_o});
		$display("rewind test done");
		test_done;
	end
endmodule // rcd_drive_test
